//--- tb_top.sv
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tb_top;
    logic        clk_i    = 1'b0;
    logic        rst_n_i  = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic        rd_en    = 1'b0;
    logic        wr_en    = 1'b0;
    logic [31:0] wdat     = 32'h0;
    logic [3:0]  ben      = 4'h0;
    logic [31:0] rdat;
    logic        wait_req;
    logic        in0;
    logic        in1;
    logic        out0;
    logic        out1;
    logic        m0_irq;
    logic        m1_irq;
    logic        ov_irq;
    logic [31:0] q, a0, a1, b0, b1;
    int          failures = 0;
    int          n_tests  = 0;
    int          m0, m1, t0, t1, ov;

    always #12.5 clk_i = ~clk_i;

    // Narrow counter so overflow comes within a short run
    tcc_timer_capture_compare #(.CNT_W(8)) tcc_timer_capture_compare_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req), .timer_in0_i(in0),
        .timer_in1_i(in1), .timer_out0_o(out0), .timer_out1_o(out1),
        .match0_irq_o(m0_irq), .match1_irq_o(m1_irq), .overflow_irq_o(ov_irq));

    tcc_pin_model pin_model_inst (.clk_i(clk_i), .pin0_o(in0), .pin1_o(in1));

    task automatic test_done;
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic limit(input int i);
        if (i >= 600) begin
            $display("mismatch timeout expected 1 seen 0");
            failures++;
            test_done;
        end
    endtask

    task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] rq);
        int i;
        i = 0;
        adr   <= a;
        rd_en <= r;
        wr_en <= !r;
        wdat  <= d;
        ben   <= b;
        do begin
            @(posedge clk_i);
            i++;
        end while (wait_req !== 1'b0 && i < 600);
        rq = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        limit(i);
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        acc(1'b0, a, d, 4'hf, x);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        acc(1'b1, a, 32'h0, 4'hf, x);
        chk(nm, e, x);
    endtask

    task automatic wev(input bit sel);
        int i;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while ((sel ? ov_irq : m0_irq) !== 1'b1 && i < 600);
        limit(i);
    endtask

    task automatic cnt(input int n);
        logic p0;
        logic p1;
        {m0, m1, t0, t1, ov} = '0;
        p0 = out0;
        p1 = out1;
        repeat (n) begin
            @(posedge clk_i);
            m0 += (m0_irq === 1'b1);
            m1 += (m1_irq === 1'b1);
            ov += (ov_irq === 1'b1);
            t0 += (out0 !== p0);
            t1 += (out1 !== p1);
            p0 = out0;
            p1 = out1;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rchk("count_reset", `TCC_OFF_COUNT, 32'h0);
        rchk("cc1_reset", `TCC_OFF_CC1, 32'h0);
        rchk("filter_reset", `TCC_OFF_FILTER, 32'h0);
        rchk("unmapped", 8'h30, 32'h0);
        wr(`TCC_OFF_FILTER, 32'h3);
        rchk("filter_rw", `TCC_OFF_FILTER, 32'h3);
        wr(`TCC_OFF_FILTER, 32'h0);
        acc(1'b0, `TCC_OFF_CC1, 32'h55, 4'h1, q);
        rchk("cc1_part_write", `TCC_OFF_CC1, 32'h0);
        wr(`TCC_OFF_COUNT, 32'h12);
        rchk("count_ro", `TCC_OFF_COUNT, 32'h0);
        wr(`TCC_OFF_OUT_CTRL, 32'h5);
        wr(`TCC_OFF_CC0, 32'h9);
        wr(`TCC_OFF_CC1, 32'h4);
        wr(`TCC_OFF_CTRL1, 32'(tcc_pkg::MODE_INTERVAL));
        wr(`TCC_OFF_CTRL0, 32'h1);
        wev(1'b0);
        cnt(100);
        chk("match0_n", 10, m0);
        chk("match1_n", 10, m1);
        chk("out0_edges", 10, t0);
        chk("out1_edges", 10, t1);
        chk("ovf_n", 0, ov);
        acc(1'b1, `TCC_OFF_COUNT, 32'h0, 4'hf, q);
        chk("count_live", 1, q <= 32'h9);
        rchk("cc1_running", `TCC_OFF_CC1, 32'h4);
        // Raising the period while running is safe: count stays below it
        wr(`TCC_OFF_CC0, 32'h13);
        wev(1'b0);
        wev(1'b0);
        cnt(100);
        chk("anytime_match0_n", 5, m0);
        wr(`TCC_OFF_CTRL0, 32'h0);
        rchk("count_stopped", `TCC_OFF_COUNT, 32'h0);
        wr(`TCC_OFF_OUT_CTRL, 32'h4);
        wr(`TCC_OFF_CC0, 32'h9);
        wr(`TCC_OFF_CTRL0, 32'h1);
        wev(1'b0);
        cnt(100);
        chk("out0_disabled", 0, t0);
        chk("out1_enabled", 10, t1);
        wr(`TCC_OFF_CTRL0, 32'h0);
        wr(`TCC_OFF_CTRL1, 32'(tcc_pkg::MODE_PWM));
        wr(`TCC_OFF_CTRL0, 32'h1);
        wev(1'b0);
        wr(`TCC_OFF_CC0, 32'h13);
        wev(1'b0);
        cnt(100);
        chk("batch_held", 10, m0);
        wr(`TCC_OFF_CC1, 32'h4);
        wev(1'b0);
        wev(1'b0);
        cnt(100);
        chk("batch_loaded", 5, m0);
        wr(`TCC_OFF_CTRL0, 32'h0);
        wr(`TCC_OFF_CTRL1, 32'(tcc_pkg::MODE_FREE_RUN));
        wr(`TCC_OFF_OPTION, 32'h30);
        wr(`TCC_OFF_CAP_EDGE, 32'hf);
        wr(`TCC_OFF_CTRL0, 32'h1);
        fork
            pin_model_inst.pulse(0, 40);
            pin_model_inst.pulse(1, 25);
        join_none
        repeat (10) @(posedge clk_i);
        acc(1'b1, `TCC_OFF_CC0, 32'h0, 4'hf, a0);
        acc(1'b1, `TCC_OFF_CC1, 32'h0, 4'hf, a1);
        repeat (40) @(posedge clk_i);
        acc(1'b1, `TCC_OFF_CC0, 32'h0, 4'hf, b0);
        acc(1'b1, `TCC_OFF_CC1, 32'h0, 4'hf, b1);
        chk("cap0_gap", 40, (b0 - a0) & 32'hff);
        chk("cap1_gap", 25, (b1 - a1) & 32'hff);
        wev(1'b1);
        cnt(512);
        chk("ovf_wraps", 2, ov);
        acc(1'b1, `TCC_OFF_OPTION, 32'h0, 4'hf, q);
        chk("ovf_flag", 1, q[0]);
        wr(`TCC_OFF_CTRL0, 32'h0);
        wr(`TCC_OFF_CTRL1, 32'h6);
        wr(`TCC_OFF_CTRL0, 32'h1);
        pin_model_inst.pulse(0, 30);
        pin_model_inst.pulse(1, 20);
        rchk("pw_width0", `TCC_OFF_CC0, 32'h1d);
        rchk("pw_width1", `TCC_OFF_CC1, 32'h13);
        wr(`TCC_OFF_CTRL0, 32'h0);
        wr(`TCC_OFF_CTRL1, 32'h3);
        wr(`TCC_OFF_CTRL0, 32'h1);
        cnt(40);
        chk("oneshot_armed", 0, m0);
        wr(`TCC_OFF_CTRL1, 32'h13);
        cnt(60);
        chk("oneshot_once", 1, m0);
        wr(`TCC_OFF_CTRL0, 32'h0);
        wr(`TCC_OFF_CAP_EDGE, 32'h0);
        wr(`TCC_OFF_TRG_EDGE, 32'h4);
        wr(`TCC_OFF_CTRL1, 32'h21);
        wr(`TCC_OFF_CTRL0, 32'h1);
        repeat (3) pin_model_inst.pulse(0, 2);
        rchk("event_n", `TCC_OFF_COUNT, 32'h2);
        test_done;
    end
endmodule

//--- tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define TCC_OFF_CTRL0     8'h00
`define TCC_OFF_CTRL1     8'h04
`define TCC_OFF_OUT_CTRL  8'h08
`define TCC_OFF_CAP_EDGE  8'h0c
`define TCC_OFF_TRG_EDGE  8'h10
`define TCC_OFF_OPTION    8'h14
`define TCC_OFF_CC0       8'h18
`define TCC_OFF_CC1       8'h1c
`define TCC_OFF_COUNT     8'h20
`define TCC_OFF_FILTER    8'h24

// Field positions
`define TCC_CTRL0_RUN     0
`define TCC_CTRL0_PRS_LO  1
`define TCC_CTRL1_MODE_LO 0
`define TCC_CTRL1_TRIG    4
`define TCC_CTRL1_EVCLK   5
`define TCC_OUT_EN0       0
`define TCC_OUT_INV0      1
`define TCC_OUT_EN1       2
`define TCC_OUT_INV1      3
`define TCC_EDGE0_LO      0
`define TCC_EDGE1_LO      2
`define TCC_OPT_OVF       0
`define TCC_OPT_SEL0      4
`define TCC_OPT_SEL1      5

// Reset values
`define TCC_RST_CC        16'h0000
`define TCC_RST_BYTE      8'h00
`define TCC_RST_NIBBLE    4'h0

`endif

//--- tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic clk_i,
    output logic      pin0_o,
    output logic      pin1_o
);
    initial begin
        pin0_o = 1'b0;
        pin1_o = 1'b0;
    end

    // One high pulse of exact width, so both edges are gap cycles apart
    task automatic pulse(input int pin, input int gap);
        @(posedge clk_i);
        if (pin == 0) pin0_o <= 1'b1;
        else pin1_o <= 1'b1;
        repeat (gap) @(posedge clk_i);
        if (pin == 0) pin0_o <= 1'b0;
        else pin1_o <= 1'b0;
    endtask
endmodule

//--- tcc_pkg.sv
package tcc_pkg;

    typedef enum logic [2:0] {
        MODE_INTERVAL  = 3'h0,
        MODE_EVENT     = 3'h1,
        MODE_EXT_TRIG  = 3'h2,
        MODE_ONE_SHOT  = 3'h3,
        MODE_PWM       = 3'h4,
        MODE_FREE_RUN  = 3'h5,
        MODE_PULSE_W   = 3'h6,
        MODE_RESERVED  = 3'h7
    } tcc_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } tcc_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } tcc_bus_req_s;

endpackage

//--- tcc_sva.sv
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_sva #(
    parameter int CNT_W = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        timer_in0_i,
    input wire logic        timer_in1_i,
    input wire logic        timer_out0_o,
    input wire logic        timer_out1_o,
    input wire logic        match0_irq_o,
    input wire logic        match1_irq_o,
    input wire logic        overflow_irq_o
);
    logic       wr_done;
    logic       rd_done;
    logic [2:0] mode_r;
    logic       run_r;
    logic [1:0] inv_r;
    logic [2:0] idle_r;

    assign wr_done = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign rd_done = avs_read_i & ~avs_waitrequest_o;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r <= 3'h0;
            run_r  <= 1'b0;
            inv_r  <= 2'h0;
        end else if (wr_done) begin
            case (avs_address_i)
                `TCC_OFF_CTRL0:    run_r <= avs_writedata_i[0];
                `TCC_OFF_CTRL1:    mode_r <= avs_writedata_i[2:0];
                `TCC_OFF_OUT_CTRL: inv_r <= {avs_writedata_i[3], avs_writedata_i[1]};
                default:           run_r <= run_r;
            endcase
        end
    end

    // Settle time after a stop or an output-control write before pins are judged
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || run_r || (wr_done && avs_address_i == `TCC_OFF_OUT_CTRL)) begin
            idle_r <= 3'h0;
        end else if (idle_r != 3'h7) begin
            idle_r <= idle_r + 3'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_wait_answer: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_zero: assert property (rd_done && avs_address_i >= 8'h28
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_cc_width: assert property (rd_done && avs_address_i inside {`TCC_OFF_CC0,
        `TCC_OFF_CC1, `TCC_OFF_COUNT} |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("word register upper bits set");
    a_filter_width: assert property (rd_done && avs_address_i == `TCC_OFF_FILTER
        |-> avs_readdata_o[31:8] == 24'h0) else $error("filter register upper bits set");
    a_count_stopped: assert property (rd_done && avs_address_i == `TCC_OFF_COUNT
        && !run_r |-> avs_readdata_o == 32'h0) else $error("count readback not zero");
    a_ovf_mode: assert property (overflow_irq_o |-> mode_r == tcc_pkg::MODE_FREE_RUN
        || mode_r == tcc_pkg::MODE_PULSE_W) else $error("overflow irq in wrong mode");
    a_irq_quiet: assert property (idle_r == 3'h7 |-> !match0_irq_o && !match1_irq_o
        && !overflow_irq_o) else $error("irq while stopped");
    a_out_idle: assert property (idle_r == 3'h7 |-> timer_out0_o == inv_r[0]
        && timer_out1_o == inv_r[1]) else $error("idle pin level wrong");

    c_match0: cover property (match0_irq_o);
    c_match1: cover property (match1_irq_o);
    c_ovf: cover property (overflow_irq_o);
    c_count_rd: cover property (rd_done && avs_address_i == `TCC_OFF_COUNT && run_r);
endmodule

bind tcc_timer_capture_compare tcc_sva #(.CNT_W(CNT_W)) tcc_sva_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .timer_in0_i(timer_in0_i),
    .timer_in1_i(timer_in1_i), .timer_out0_o(timer_out0_o), .timer_out1_o(timer_out1_o),
    .match0_irq_o(match0_irq_o), .match1_irq_o(match1_irq_o),
    .overflow_irq_o(overflow_irq_o));

//--- tcc_timer_capture_compare.sv
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_timer_capture_compare #(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        timer_in0_i,
    input  wire logic        timer_in1_i,
    output logic             timer_out0_o,
    output logic             timer_out1_o,
    output logic             match0_irq_o,
    output logic             match1_irq_o,
    output logic             overflow_irq_o
);

    if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 8 and 16");
    end

    localparam logic [CNT_W-1:0] CNT_FULL = '1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    endfunction

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    tcc_pkg::tcc_bus_req_s bus;
    tcc_pkg::tcc_state_e   state_r;
    tcc_pkg::tcc_mode_e    mode;

    logic             wait_r;
    logic [31:0]      rdata_r;
    logic [31:0]      rd_mux;
    logic             wr_acc;
    logic             wr16;
    logic [3:0]       ctrl0_r;
    logic [2:0]       mode_r;
    logic             evclk_r;
    logic             trig_pulse_r;
    logic [3:0]       out_ctrl_r;
    logic [3:0]       cap_edge_r;
    logic [3:0]       trg_edge_r;
    logic             sel0_r;
    logic             sel1_r;
    logic             ovf_r;
    logic [7:0]       filter_r;
    logic [CNT_W-1:0] cc0_r;
    logic [CNT_W-1:0] cc1_r;
    logic [CNT_W-1:0] sh0_r;
    logic [CNT_W-1:0] sh1_r;
    logic [CNT_W-1:0] cnt_r;
    logic             first_r;
    logic             pend_r;
    logic [6:0]       presc_r;
    logic [7:0]       presc_one;
    logic [6:0]       presc_mask;
    logic [1:0]       pin_raw;
    logic [1:0]       samp_r;
    logic [1:0]       filt_r;
    logic [1:0]       prev_r;
    logic             tog0_r;
    logic             tog1_r;
    logic             out0_r;
    logic             out1_r;
    logic             m0_irq_r;
    logic             m1_irq_r;
    logic             ov_irq_r;

    logic run_en;
    logic is_free;
    logic is_pw;
    logic cyc_mode;
    logic batch_mode;
    logic trig_mode;
    logic cap0_mode;
    logic cap1_mode;
    logic cap0_ev;
    logic cap1_ev;
    logic trig_ev;
    logic tick;
    logic counting;
    logic match0;
    logic match1;
    logic ovf_ev;
    logic batch_load;

    // Avalon-MM slave: one wait cycle, read data latched when the request is seen
    assign bus.read  = avs_read_i;
    assign bus.write = avs_write_i;
    assign bus.addr  = avs_address_i;
    assign bus.wdata = avs_writedata_i;
    assign bus.be    = avs_byteenable_i;

    assign wr_acc = bus.write & ~wait_r;
    assign wr16   = (bus.be[1:0] == 2'b11);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~((bus.read | bus.write) & wait_r);
        end
    end

    // Snapshot taken one edge before completion; a capture at that edge cannot tear it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus.read & wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_hit(bus.addr, `TCC_OFF_CTRL0)) begin
            rd_mux[3:0] = ctrl0_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_CTRL1)) begin
            rd_mux[2:0] = mode_r;
            rd_mux[`TCC_CTRL1_EVCLK] = evclk_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_OUT_CTRL)) begin
            rd_mux[3:0] = out_ctrl_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_CAP_EDGE)) begin
            rd_mux[3:0] = cap_edge_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_TRG_EDGE)) begin
            rd_mux[3:0] = trg_edge_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_OPTION)) begin
            rd_mux[`TCC_OPT_OVF]  = ovf_r;
            rd_mux[`TCC_OPT_SEL0] = sel0_r;
            rd_mux[`TCC_OPT_SEL1] = sel1_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_CC0)) begin
            rd_mux[CNT_W-1:0] = cc0_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_CC1)) begin
            rd_mux[CNT_W-1:0] = cc1_r;
        end else if (addr_hit(bus.addr, `TCC_OFF_COUNT)) begin
            rd_mux[CNT_W-1:0] = run_en ? cnt_r : CNT_ZERO;
        end else if (addr_hit(bus.addr, `TCC_OFF_FILTER)) begin
            rd_mux[7:0] = filter_r;
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl0_r <= `TCC_RST_NIBBLE;
        end else if (wr_acc && bus.be[0] && addr_hit(bus.addr, `TCC_OFF_CTRL0)) begin
            ctrl0_r <= bus.wdata[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r       <= 3'h0;
            evclk_r      <= 1'b0;
            trig_pulse_r <= 1'b0;
        end else begin
            trig_pulse_r <= 1'b0;
            if (wr_acc && bus.be[0] && addr_hit(bus.addr, `TCC_OFF_CTRL1)) begin
                mode_r       <= bus.wdata[2:0];
                evclk_r      <= bus.wdata[`TCC_CTRL1_EVCLK];
                trig_pulse_r <= bus.wdata[`TCC_CTRL1_TRIG];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_ctrl_r <= `TCC_RST_NIBBLE;
            cap_edge_r <= `TCC_RST_NIBBLE;
            trg_edge_r <= `TCC_RST_NIBBLE;
        end else if (wr_acc && bus.be[0]) begin
            if (addr_hit(bus.addr, `TCC_OFF_OUT_CTRL)) begin
                out_ctrl_r <= bus.wdata[3:0];
            end else if (addr_hit(bus.addr, `TCC_OFF_CAP_EDGE)) begin
                cap_edge_r <= bus.wdata[3:0];
            end else if (addr_hit(bus.addr, `TCC_OFF_TRG_EDGE)) begin
                trg_edge_r <= bus.wdata[3:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel0_r <= 1'b0;
            sel1_r <= 1'b0;
        end else if (wr_acc && bus.be[0] && addr_hit(bus.addr, `TCC_OFF_OPTION)) begin
            sel0_r <= bus.wdata[`TCC_OPT_SEL0];
            sel1_r <= bus.wdata[`TCC_OPT_SEL1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            filter_r <= `TCC_RST_BYTE;
        end else if (wr_acc && bus.be[0] && addr_hit(bus.addr, `TCC_OFF_FILTER)) begin
            filter_r <= bus.wdata[7:0];
        end
    end

    // Mode decode
    assign mode       = tcc_pkg::tcc_mode_e'(mode_r);
    assign run_en     = ctrl0_r[`TCC_CTRL0_RUN];
    assign is_free    = (mode == tcc_pkg::MODE_FREE_RUN);
    assign is_pw      = (mode == tcc_pkg::MODE_PULSE_W);
    assign trig_mode  = (mode == tcc_pkg::MODE_EXT_TRIG) || (mode == tcc_pkg::MODE_ONE_SHOT);
    assign batch_mode = (mode == tcc_pkg::MODE_EXT_TRIG) || (mode == tcc_pkg::MODE_PWM);
    assign cyc_mode   = (mode_r <= 3'h4);
    assign cap0_mode  = (is_free & sel0_r) | is_pw;
    assign cap1_mode  = (is_free & sel1_r) | is_pw;

    // Input pins: optional two-sample agreement filter per pin
    assign pin_raw = {timer_in1_i, timer_in0_i};

    for (genvar g = 0; g < 2; g++) begin : g_pin
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                samp_r[g] <= 1'b0;
                filt_r[g] <= 1'b0;
                prev_r[g] <= 1'b0;
            end else begin
                samp_r[g] <= pin_raw[g];
                prev_r[g] <= filt_r[g];
                if (!filter_r[g] || (samp_r[g] == pin_raw[g])) begin
                    filt_r[g] <= pin_raw[g];
                end
            end
        end
    end

    assign cap0_ev = run_en & cap0_mode
                   & edge_hit(cap_edge_r[`TCC_EDGE0_LO +: 2], prev_r[0], filt_r[0]);
    assign cap1_ev = run_en & cap1_mode
                   & edge_hit(cap_edge_r[`TCC_EDGE1_LO +: 2], prev_r[1], filt_r[1]);
    assign trig_ev = run_en & trig_mode & (trig_pulse_r
                   | edge_hit(trg_edge_r[`TCC_EDGE0_LO +: 2], prev_r[0], filt_r[0]));

    // Count clock: prescaled system clock or counted edges on in0
    assign presc_one  = 8'h01 << ctrl0_r[`TCC_CTRL0_PRS_LO +: 3];
    assign presc_mask = 7'(presc_one - 8'h01);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en) begin
            presc_r <= 7'h00;
        end else begin
            presc_r <= presc_r + 7'h01;
        end
    end

    assign tick = evclk_r
                ? edge_hit(trg_edge_r[`TCC_EDGE1_LO +: 2], prev_r[0], filt_r[0])
                : ((presc_r & presc_mask) == presc_mask);

    assign counting   = (state_r == tcc_pkg::ST_RUN) & tick & ~first_r;
    assign match0     = counting & ~cap0_mode & (cnt_r == sh0_r);
    assign match1     = counting & ~cap1_mode & (cnt_r == sh1_r);
    assign ovf_ev     = counting & (is_free | is_pw) & (cnt_r == CNT_FULL) & ~(cyc_mode & match0);
    assign batch_load = (state_r == tcc_pkg::ST_RUN) & tick & first_r | (match0 & pend_r);

    // Sequencer: idle while stopped, armed while awaiting a trigger, running
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en) begin
            state_r <= tcc_pkg::ST_IDLE;
            first_r <= 1'b0;
        end else begin
            case (state_r)
                tcc_pkg::ST_IDLE: begin
                    first_r <= 1'b1;
                    state_r <= trig_mode ? tcc_pkg::ST_ARM : tcc_pkg::ST_RUN;
                end
                tcc_pkg::ST_ARM: begin
                    if (trig_ev) begin
                        state_r <= tcc_pkg::ST_RUN;
                        first_r <= 1'b1;
                    end
                end
                tcc_pkg::ST_RUN: begin
                    if (trig_ev && mode == tcc_pkg::MODE_EXT_TRIG) begin
                        first_r <= 1'b1;
                    end else if (match0 && mode == tcc_pkg::MODE_ONE_SHOT) begin
                        state_r <= tcc_pkg::ST_ARM;
                    end else if (tick) begin
                        first_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= tcc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // The counter rests at all ones while stopped or armed
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en || state_r != tcc_pkg::ST_RUN) begin
            cnt_r <= CNT_FULL;
        end else if (trig_ev && mode == tcc_pkg::MODE_EXT_TRIG) begin
            cnt_r <= CNT_FULL;
        end else if (match0 && mode == tcc_pkg::MODE_ONE_SHOT) begin
            cnt_r <= CNT_FULL;
        end else if (is_pw && (cap0_ev || cap1_ev)) begin
            cnt_r <= CNT_ZERO;
        end else if (tick) begin
            if (first_r) begin
                cnt_r <= CNT_ZERO;
            end else if (cyc_mode && match0) begin
                cnt_r <= CNT_ZERO;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // Capture/compare registers; a capture wins over a same-cycle write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cc0_r <= CNT_W'(`TCC_RST_CC);
        end else if (cap0_ev) begin
            cc0_r <= cnt_r;
        end else if (wr_acc && wr16 && addr_hit(bus.addr, `TCC_OFF_CC0)) begin
            cc0_r <= bus.wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cc1_r <= CNT_W'(`TCC_RST_CC);
        end else if (cap1_ev) begin
            cc1_r <= cnt_r;
        end else if (wr_acc && wr16 && addr_hit(bus.addr, `TCC_OFF_CC1)) begin
            cc1_r <= bus.wdata[CNT_W-1:0];
        end
    end

    // Batch transfer armed by the write to register 1, taken at the cycle boundary
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en || !batch_mode) begin
            pend_r <= 1'b0;
        end else if (wr_acc && wr16 && addr_hit(bus.addr, `TCC_OFF_CC1)) begin
            pend_r <= 1'b1;
        end else if (batch_load) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sh0_r <= CNT_W'(`TCC_RST_CC);
            sh1_r <= CNT_W'(`TCC_RST_CC);
        end else if (!batch_mode || batch_load) begin
            sh0_r <= cc0_r;
            sh1_r <= cc1_r;
        end
    end

    // Overflow flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en) begin
            ovf_r <= 1'b0;
        end else if (ovf_ev) begin
            ovf_r <= 1'b1;
        end else if (wr_acc && bus.be[0] && addr_hit(bus.addr, `TCC_OFF_OPTION)
                     && !bus.wdata[`TCC_OPT_OVF]) begin
            ovf_r <= 1'b0;
        end
    end

    // Output pins: the enable gates the toggle at a match and also masks the pin level every cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_en) begin
            tog0_r <= 1'b0;
            tog1_r <= 1'b0;
        end else begin
            if (match0 && out_ctrl_r[`TCC_OUT_EN0]) begin
                tog0_r <= ~tog0_r;
            end
            if (match1 && out_ctrl_r[`TCC_OUT_EN1]) begin
                tog1_r <= ~tog1_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out0_r <= 1'b0;
            out1_r <= 1'b0;
        end else begin
            out0_r <= (out_ctrl_r[`TCC_OUT_EN0] & tog0_r) ^ out_ctrl_r[`TCC_OUT_INV0];
            out1_r <= (out_ctrl_r[`TCC_OUT_EN1] & tog1_r) ^ out_ctrl_r[`TCC_OUT_INV1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            m0_irq_r <= 1'b0;
            m1_irq_r <= 1'b0;
            ov_irq_r <= 1'b0;
        end else begin
            m0_irq_r <= match0;
            m1_irq_r <= match1;
            ov_irq_r <= ovf_ev;
        end
    end

    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign timer_out0_o      = out0_r;
    assign timer_out1_o      = out1_r;
    assign match0_irq_o      = m0_irq_r;
    assign match1_irq_o      = m1_irq_r;
    assign overflow_irq_o    = ov_irq_r;

endmodule
